// ---- core/afs_pkg.sv ----
/*
  package for the automatic fan speed loop: register offsets, field positions,
  reset values and timing counts.
  assumes a 25 MHz core clock.
*/
`default_nettype none
package afs_pkg;
  localparam int CLK_HZ = 25_000_000;
  // register offsets
  localparam logic [7:0] ADDR_LOOP_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_FAN1_CHAR = 8'h20;
  localparam logic [7:0] ADDR_FAN2_CHAR = 8'h21;
  localparam logic [7:0] ADDR_MIN_DUTY = 8'h22;
  localparam logic [7:0] ADDR_LOCAL_LOOP = 8'h24;
  localparam logic [7:0] ADDR_REMOTE1_LOOP = 8'h25;
  localparam logic [7:0] ADDR_REMOTE2_LOOP = 8'h26;
  // reset values
  localparam logic [7:0] RST_LOOP_CONFIG = 8'h80;
  localparam logic [7:0] RST_FAN_CHAR = 8'h1D;
  localparam logic [7:0] RST_MIN_DUTY = 8'h55;
  localparam logic [7:0] RST_LOCAL_LOOP = 8'h44;
  localparam logic [7:0] RST_REMOTE_LOOP = 8'h64;
  // field positions
  localparam int AUTO_BIT = 7;
  localparam int ROUTE_HI = 6;
  localparam int ROUTE_LO = 5;
  localparam int SPIN_HI = 2;
  localparam int SPIN_LO = 0;
  localparam int TON_HI = 7;
  localparam int TON_LO = 3;
  localparam int SPAN_HI = 2;
  localparam int SPAN_LO = 0;
  // routing codes
  localparam logic [1:0] ROUTE_SPLIT = 2'h0;
  localparam logic [1:0] ROUTE_R1 = 2'h1;
  localparam logic [1:0] ROUTE_R2 = 2'h2;
  localparam logic [1:0] ROUTE_FASTEST = 2'h3;
  // duty code and turn-off hysteresis
  localparam logic [3:0] MAX_DUTY_CODE = 4'hF;
  localparam logic [7:0] HYST_DEGC = 8'h05;
  // timing
  localparam int SPIN_TICK_MS = 200;
  localparam int SPIN_TICK_CYCLES = CLK_HZ / 1000 * SPIN_TICK_MS;
  localparam int PWM_SLOTS = 240;
  localparam int PWM_FREQ_X4_HZ = 125;
  localparam int PWM_SLOT_CYCLES = CLK_HZ * 4 / (PWM_FREQ_X4_HZ * PWM_SLOTS);
  localparam logic [7:0] PWM_LAST_SLOT = 8'(PWM_SLOTS - 1);
endpackage : afs_pkg
`default_nettype wire

// ---- core/afs_pwm_out.sv ----
/*
  one pwm output: 240 slots per period, duty code times 16 slots high.
  assumes slot_en is a one-cycle pulse from the caller's divider.
*/
`default_nettype none
module afs_pwm_out (
  input wire logic clk,
  input wire logic srst,
  input wire logic slot_en,
  input wire logic [3:0] duty_code,
  output logic pwm
);
  typedef struct packed {
    logic [7:0] cnt;
    logic pwm;
  } afs_pwm_s;

  afs_pwm_s st_r;
  afs_pwm_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (slot_en) begin
      st_nxt.cnt = (st_r.cnt == afs_pkg::PWM_LAST_SLOT) ? 8'h00 : st_r.cnt + 8'h01;
      // code 15 gives 240 slots, so full duty never drops low
      st_nxt.pwm = st_nxt.cnt < {duty_code, 4'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pwm = st_r.pwm;
endmodule : afs_pwm_out
`default_nettype wire

// ---- core/afs_fan_loop.sv ----
/*
  automatic fan speed loop for two pwm fans, with its register bank.
  assumes temperatures are whole degrees c, unsigned, from logic on clk,
  and the register port is driven synchronously to clk.
*/
`default_nettype none
module afs_fan_loop #(
  parameter int TICK_CYCLES = afs_pkg::SPIN_TICK_CYCLES,
  parameter int SLOT_CYCLES = afs_pkg::PWM_SLOT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote1_temp,
  input wire logic [7:0] remote2_temp,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [3:0] fan1_duty_code,
  output logic [3:0] fan2_duty_code,
  output logic fan1_pwm,
  output logic fan2_pwm
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int SW = $clog2(SLOT_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYCLES - 1);

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] fc1;
    logic [7:0] fc2;
    logic [7:0] mind;
    logic [7:0] tl;
    logic [7:0] tr1;
    logic [7:0] tr2;
    logic [7:0] rdata;
    logic [2:0] ch_on;
    logic [1:0] fan_on;
    logic [5:0] spin1;
    logic [5:0] spin2;
    logic [3:0] code1;
    logic [3:0] code2;
    logic [TW-1:0] tick;
    logic [SW-1:0] slot;
  } afs_state_s;

  afs_state_s st_r;
  afs_state_s st_nxt;
  logic slot_en;

  function automatic logic [7:0] ton_degc(input logic [7:0] loop);
    ton_degc = {1'b0, loop[afs_pkg::TON_HI:afs_pkg::TON_LO], 2'b00};
  endfunction : ton_degc

  // duty code for one channel against one fan's minimum code
  function automatic logic [3:0] chan_duty(input logic [7:0] temp, input logic [7:0] loop,
                                           input logic [3:0] min_code);
    logic [7:0] ton;
    logic [7:0] diff;
    logic [9:0] steps;
    logic [9:0] sum;
    ton = ton_degc(loop);
    diff = (temp > ton) ? temp - ton : 8'h00;
    // ten steps per span: shift replaces the divide
    case (loop[afs_pkg::SPAN_HI:afs_pkg::SPAN_LO])
      3'h0: steps = {1'b0, diff, 1'b0};
      3'h1: steps = {2'b00, diff};
      3'h2: steps = {3'b000, diff[7:1]};
      3'h3: steps = {4'h0, diff[7:2]};
      default: steps = {5'h00, diff[7:3]};
    endcase
    sum = {6'h00, min_code} + steps;
    chan_duty = (sum > {6'h00, afs_pkg::MAX_DUTY_CODE}) ? afs_pkg::MAX_DUTY_CODE : sum[3:0];
  endfunction : chan_duty

  function automatic logic [5:0] spin_ticks(input logic [2:0] code);
    case (code)
      3'h0: spin_ticks = 6'h01;
      3'h1: spin_ticks = 6'h02;
      3'h2: spin_ticks = 6'h03;
      3'h3: spin_ticks = 6'h04;
      3'h4: spin_ticks = 6'h05;
      3'h5: spin_ticks = 6'h0A;
      3'h6: spin_ticks = 6'h14;
      default: spin_ticks = 6'h28;
    endcase
  endfunction : spin_ticks

  function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
    max4 = (a > b) ? a : b;
  endfunction : max4

  logic [7:0] temps [3];
  logic [7:0] loops [3];
  logic [3:0] duty1 [3];
  logic [3:0] duty2 [3];
  logic [1:0] dem_on;
  logic [3:0] dem1;
  logic [3:0] dem2;
  logic tick_en;

  always_comb begin
    temps[0] = local_temp;
    temps[1] = remote1_temp;
    temps[2] = remote2_temp;
    loops[0] = st_r.tl;
    loops[1] = st_r.tr1;
    loops[2] = st_r.tr2;
    st_nxt = st_r;
    dem_on = 2'b00;
    dem1 = 4'h0;
    dem2 = 4'h0;
    tick_en = st_r.tick == TICK_LAST;
    st_nxt.tick = tick_en ? '0 : st_r.tick + TW'(1);
    st_nxt.slot = slot_en ? '0 : st_r.slot + SW'(1);

    // register port
    if (reg_wr) begin
      case (reg_addr)
        afs_pkg::ADDR_LOOP_CONFIG: st_nxt.cfg = reg_wdata;
        afs_pkg::ADDR_FAN1_CHAR: st_nxt.fc1 = reg_wdata;
        afs_pkg::ADDR_FAN2_CHAR: st_nxt.fc2 = reg_wdata;
        afs_pkg::ADDR_MIN_DUTY: st_nxt.mind = reg_wdata;
        afs_pkg::ADDR_LOCAL_LOOP: st_nxt.tl = reg_wdata;
        afs_pkg::ADDR_REMOTE1_LOOP: st_nxt.tr1 = reg_wdata;
        afs_pkg::ADDR_REMOTE2_LOOP: st_nxt.tr2 = reg_wdata;
        default: st_nxt.cfg = st_r.cfg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        afs_pkg::ADDR_LOOP_CONFIG: st_nxt.rdata = st_r.cfg;
        afs_pkg::ADDR_FAN1_CHAR: st_nxt.rdata = st_r.fc1;
        afs_pkg::ADDR_FAN2_CHAR: st_nxt.rdata = st_r.fc2;
        afs_pkg::ADDR_MIN_DUTY: st_nxt.rdata = st_r.mind;
        afs_pkg::ADDR_LOCAL_LOOP: st_nxt.rdata = st_r.tl;
        afs_pkg::ADDR_REMOTE1_LOOP: st_nxt.rdata = st_r.tr1;
        afs_pkg::ADDR_REMOTE2_LOOP: st_nxt.rdata = st_r.tr2;
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    // per-channel on state with turn-off hysteresis
    for (int c = 0; c < 3; c++) begin
      duty1[c] = chan_duty(temps[c], loops[c], st_r.mind[3:0]);
      duty2[c] = chan_duty(temps[c], loops[c], st_r.mind[7:4]);
      if (temps[c] > ton_degc(loops[c])) begin
        st_nxt.ch_on[c] = 1'b1;
      end else if ({1'b0, temps[c]} + {1'b0, afs_pkg::HYST_DEGC} < {1'b0, ton_degc(loops[c])}) begin
        st_nxt.ch_on[c] = 1'b0;
      end
    end

    case (st_r.cfg[afs_pkg::ROUTE_HI:afs_pkg::ROUTE_LO])
      afs_pkg::ROUTE_SPLIT: begin
        dem_on = {st_r.ch_on[2], st_r.ch_on[1]};
        dem1 = duty1[1];
        dem2 = duty2[2];
      end
      afs_pkg::ROUTE_R1: begin
        dem_on = {2{st_r.ch_on[1]}};
        dem1 = duty1[1];
        dem2 = duty2[1];
      end
      afs_pkg::ROUTE_R2: begin
        dem_on = {2{st_r.ch_on[2]}};
        dem1 = duty1[2];
        dem2 = duty2[2];
      end
      default: begin
        // fastest computed speed, not hottest channel; off channels ignored
        dem_on = {2{|st_r.ch_on}};
        for (int c = 0; c < 3; c++) begin
          if (st_r.ch_on[c]) begin
            dem1 = max4(dem1, duty1[c]);
            dem2 = max4(dem2, duty2[c]);
          end
        end
      end
    endcase

    // fan 1 spin-up; one extra tick since the tick divider free-runs
    if (!st_r.fan_on[0] && dem_on[0]) begin
      st_nxt.fan_on[0] = 1'b1;
      st_nxt.spin1 = spin_ticks(st_r.fc1[afs_pkg::SPIN_HI:afs_pkg::SPIN_LO]) + 6'h01;
    end else if (!dem_on[0]) begin
      st_nxt.fan_on[0] = 1'b0;
      st_nxt.spin1 = 6'h00;
    end else if (tick_en && st_r.spin1 != 6'h00) begin
      st_nxt.spin1 = st_r.spin1 - 6'h01;
    end
    if (!st_r.fan_on[1] && dem_on[1]) begin
      st_nxt.fan_on[1] = 1'b1;
      st_nxt.spin2 = spin_ticks(st_r.fc2[afs_pkg::SPIN_HI:afs_pkg::SPIN_LO]) + 6'h01;
    end else if (!dem_on[1]) begin
      st_nxt.fan_on[1] = 1'b0;
      st_nxt.spin2 = 6'h00;
    end else if (tick_en && st_r.spin2 != 6'h00) begin
      st_nxt.spin2 = st_r.spin2 - 6'h01;
    end

    st_nxt.code1 = !st_r.fan_on[0] ? 4'h0 : (st_r.spin1 != 6'h00) ? afs_pkg::MAX_DUTY_CODE : dem1;
    st_nxt.code2 = !st_r.fan_on[1] ? 4'h0 : (st_r.spin2 != 6'h00) ? afs_pkg::MAX_DUTY_CODE : dem2;

    // software mode: loop parked, fans off, so re-entry always spins up
    if (!st_r.cfg[afs_pkg::AUTO_BIT]) begin
      st_nxt.fan_on = 2'b00;
      st_nxt.spin1 = 6'h00;
      st_nxt.spin2 = 6'h00;
      st_nxt.code1 = 4'h0;
      st_nxt.code2 = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.cfg <= afs_pkg::RST_LOOP_CONFIG;
      st_r.fc1 <= afs_pkg::RST_FAN_CHAR;
      st_r.fc2 <= afs_pkg::RST_FAN_CHAR;
      st_r.mind <= afs_pkg::RST_MIN_DUTY;
      st_r.tl <= afs_pkg::RST_LOCAL_LOOP;
      st_r.tr1 <= afs_pkg::RST_REMOTE_LOOP;
      st_r.tr2 <= afs_pkg::RST_REMOTE_LOOP;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign slot_en = st_r.slot == SLOT_LAST;
  assign reg_rdata = st_r.rdata;
  assign fan1_duty_code = st_r.code1;
  assign fan2_duty_code = st_r.code2;

  afs_pwm_out u_pwm1 (
    .clk(clk),
    .srst(srst),
    .slot_en(slot_en),
    .duty_code(st_r.code1),
    .pwm(fan1_pwm)
  );

  afs_pwm_out u_pwm2 (
    .clk(clk),
    .srst(srst),
    .slot_en(slot_en),
    .duty_code(st_r.code2),
    .pwm(fan2_pwm)
  );
endmodule : afs_fan_loop
`default_nettype wire

// ---- dv/afs_fan_model.sv ----
/*
  fan partner: counts pwm high cycles over each window of one pwm period.
  assumes period = 240 slots of SLOT_CYCLES cycles; any window alignment works.
*/
`default_nettype none
module afs_fan_model #(
  parameter int PERIOD = 480
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic pwm1,
  input wire logic pwm2,
  output logic win_done,
  output logic [15:0] hi1,
  output logic [15:0] hi2
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic [15:0] acc1, acc2;
  // a periodic wave gives the same count in any full-period window
  always @(posedge clk) begin
    win_done <= 1'b0;
    if (srst || cnt == PERIOD - 1) begin
      hi1 <= acc1 + 16'(pwm1);
      hi2 <= acc2 + 16'(pwm2);
      win_done <= !srst;
      acc1 <= 16'h0000;
      acc2 <= 16'h0000;
      cnt <= 0;
    end else begin
      acc1 <= acc1 + 16'(pwm1);
      acc2 <= acc2 + 16'(pwm2);
      cnt <= cnt + 1;
    end
  end
endmodule : afs_fan_model
`default_nettype wire

// ---- dv/afs_fan_loop_chk.sv ----
/*
  port checker for the fan loop.
  assumes it is bound into afs_fan_loop, one clock domain.
*/
`default_nettype none
module afs_fan_loop_chk #(
  parameter int TICK_CYCLES = 20,
  parameter int SLOT_CYCLES = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote1_temp,
  input wire logic [7:0] remote2_temp,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] fan1_duty_code,
  input wire logic [3:0] fan2_duty_code,
  input wire logic fan1_pwm,
  input wire logic fan2_pwm
);
  timeunit 1ns;
  timeprecision 1ns;
  logic auto_r;
  logic [7:0] mind_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      auto_r <= 1'b1;
      mind_r <= afs_pkg::RST_MIN_DUTY;
    end else begin
      if (reg_wr && reg_addr == afs_pkg::ADDR_LOOP_CONFIG) begin
        auto_r <= reg_wdata[afs_pkg::AUTO_BIT];
      end
      if (reg_wr && reg_addr == afs_pkg::ADDR_MIN_DUTY) begin
        mind_r <= reg_wdata;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst;
    disable iff (1'b0) srst |=> reg_rdata == 8'h00 && fan1_duty_code == 4'h0 && !fan2_pwm;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_cfg_rd;
    reg_rd && reg_addr == afs_pkg::ADDR_LOOP_CONFIG |=> reg_rdata[7] == $past(auto_r);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("mode bit readback");
  property p_wr_rd;
    reg_wr && reg_addr == 8'h21 ##2 reg_rd && reg_addr == 8'h21
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("fan char readback");
  property p_mode;
    !auto_r [*4] |-> fan1_duty_code == 4'h0 && fan2_duty_code == 4'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("fans run with mode off");
  // min code 0 lets a running fan climb from 0 with no spin-up, so skip it
  property p_spin1;
    mind_r[3:0] != 4'h0 && $past(fan1_duty_code) == 4'h0 && fan1_duty_code != 4'h0
      |-> fan1_duty_code == 4'hF [*8];
  endproperty
  a_spin1: assert property (p_spin1) else $error("fan1 spin-up short");
  property p_spin2;
    mind_r[7:4] != 4'h0 && $past(fan2_duty_code) == 4'h0 && fan2_duty_code != 4'h0
      |-> fan2_duty_code == 4'hF [*8];
  endproperty
  a_spin2: assert property (p_spin2) else $error("fan2 spin-up short");
  property p_pwm_off;
    fan1_duty_code == 4'h0 [*5] |-> !fan1_pwm;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm high at zero duty");
  property p_pwm_full;
    fan2_duty_code == 4'hF [*5] |-> fan2_pwm;
  endproperty
  a_pwm_full: assert property (p_pwm_full) else $error("pwm low at full duty");
  c_spin: cover property (fan1_duty_code == 4'h0 ##1 fan1_duty_code == 4'hF);
  c_both: cover property (fan1_duty_code != 4'h0 && fan2_duty_code != 4'h0);
  c_off: cover property (!auto_r [*4]);
endmodule : afs_fan_loop_chk
`default_nettype wire

// ---- dv/auto_fan_speed_loop_tb.sv ----
/*
  bench for the fan loop: register tasks, temperature stimulus, fan model.
  assumes design, checker and model compiled first; short tick and slot counts.
*/
`default_nettype none
module auto_fan_speed_loop_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOT = 2;
  logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0, win_done;
  logic [7:0] lt = 8'h14, r1 = 8'h28, r2 = 8'h14, reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, exp_q[$];
  logic [3:0] fan1_duty_code, fan2_duty_code;
  logic fan1_pwm, fan2_pwm;
  logic [15:0] hi1, hi2;
  int err_count = 0, check_count = 0;
  int spv[5] = '{5, 10, 20, 40, 80};
  logic [7:0] ra[8] = '{8'h00, 8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h30};
  logic [7:0] rv[8] = '{8'h80, 8'h1D, 8'h1D, 8'h55, 8'h44, 8'h64, 8'h64, 8'h00};
  initial forever #20 clk = ~clk;
  afs_fan_loop #(.TICK_CYCLES(20), .SLOT_CYCLES(SLOT)) dut (.clk(clk), .srst(srst),
    .local_temp(lt), .remote1_temp(r1), .remote2_temp(r2), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fan1_duty_code(fan1_duty_code), .fan2_duty_code(fan2_duty_code),
    .fan1_pwm(fan1_pwm), .fan2_pwm(fan2_pwm));
  afs_fan_model #(.PERIOD(240 * SLOT)) u_fans (.clk(clk), .srst(srst), .pwm1(fan1_pwm),
    .pwm2(fan2_pwm), .win_done(win_done), .hi1(hi1), .hi2(hi2));
  task automatic check(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  function automatic logic [3:0] dc(input int mn, off, sp);
    int v;
    v = mn + off * 10 / sp;
    return (v > 15) ? 4'hF : 4'(v);
  endfunction : dc
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // bounded wait, so a stuck loop still reports its last code
  task automatic settle(input logic [3:0] e1, e2);
    for (int i = 0; i < 400 && !(fan1_duty_code === e1 && fan2_duty_code === e2); i++)
      @(posedge clk);
    check("fan1_duty_code", {12'h000, fan1_duty_code}, {12'h000, e1});
    check("fan2_duty_code", {12'h000, fan2_duty_code}, {12'h000, e2});
  endtask : settle
  always @(posedge clk) begin
    rd_p <= reg_rd;
    if (rd_p) check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    logic [7:0] wd;
    int spin_n;
    void'($urandom(33582));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h00, 8'h00);
    wd = {5'($urandom), 3'h0};
    wr(8'h21, wd);
    rd(8'h21, wd);
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h00);
    wr(8'h22, 8'h83);
    wr(8'h24, 8'h43);
    wr(8'h26, 8'h40);
    lt <= 8'($urandom_range(31, 0));
    r1 <= 8'($urandom_range(47, 0));
    r2 <= 8'($urandom_range(31, 0));
    wr(8'h00, 8'h80);
    settle(4'h0, 4'h0);
    r1 <= 8'h37;
    for (int s = 0; s < 5; s++) begin
      wr(8'h25, {5'h0C, 3'(s)});
      settle(dc(3, 7, spv[s]), 4'h0);
    end
    r1 <= 8'h2B;
    repeat (10) @(posedge clk);
    settle(4'h3, 4'h0);
    r1 <= 8'h2A;
    settle(4'h0, 4'h0);
    r1 <= 8'h37;
    wr(8'h25, 8'h63);
    wr(8'h00, 8'hA0);
    settle(dc(3, 7, 40), dc(8, 7, 40));
    r2 <= 8'h21;
    wr(8'h00, 8'hC0);
    settle(dc(3, 1, 5), dc(8, 1, 5));
    lt <= 8'h3C;
    r1 <= 8'h46;
    wr(8'h00, 8'hE0);
    settle(dc(3, 28, 40), dc(8, 28, 40));
    @(posedge win_done);
    @(posedge win_done);
    check("fan1_pwm", hi1, 16'(10 * 16 * SLOT));
    check("fan2_pwm", hi2, 16'(15 * 16 * SLOT));
    wr(8'h00, 8'h60);
    settle(4'h0, 4'h0);
    // mid-run reset: mode bit comes back and the default spin-up runs
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(8'h00, 8'h80);
    for (int i = 0; i < 20 && fan1_duty_code !== 4'hF; i++) @(posedge clk);
    spin_n = 0;
    while (fan1_duty_code === 4'hF && spin_n < 400) begin
      @(posedge clk);
      spin_n++;
    end
    // code 101: ten ticks of 20 cycles, plus up to one tick of divider phase
    check("spin_cycles", 16'(spin_n > 200 && spin_n <= 220), 16'h0001);
    settle(dc(5, 22, 80), 4'h0);
    report_and_stop();
  end
endmodule : auto_fan_speed_loop_tb
bind afs_fan_loop afs_fan_loop_chk #(.TICK_CYCLES(TICK_CYCLES), .SLOT_CYCLES(SLOT_CYCLES))
  u_chk (.clk(clk), .srst(srst), .local_temp(local_temp), .remote1_temp(remote1_temp),
  .remote2_temp(remote2_temp), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fan1_duty_code(fan1_duty_code),
  .fan2_duty_code(fan2_duty_code), .fan1_pwm(fan1_pwm), .fan2_pwm(fan2_pwm));
`default_nettype wire
